// file: hw/tlic_pkg.sv
`default_nettype none
package tlic_pkg;
    // ************************************************************
    // register addresses
    // ************************************************************
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'ha8;
    localparam logic [7:0] ADDR_SEC_ENABLE = 8'ha9;
    localparam logic [7:0] ADDR_LEVEL_SEL  = 8'hb8;
    localparam logic [7:0] ADDR_WDOG_CFG   = 8'hc0;
    localparam logic [7:0] RST_IRQ_ENABLE  = 8'h00;
    localparam logic [7:0] RST_SEC_ENABLE  = 8'ha0;
    localparam logic [7:0] RST_LEVEL_SEL   = 8'h00;
    localparam logic [7:0] RST_WDOG_CFG    = 8'h10;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int GLOBAL_EN_BIT  = 7;
    localparam int RTC_LVL_BIT    = 6;
    localparam int SER_LVL_BIT    = 4;
    localparam int METER_EN_BIT   = 3;
    localparam int RTC_EN_BIT     = 2;
    localparam int SUPPLY_EN_BIT  = 1;
    localparam int SER_EN_BIT     = 0;
    localparam int WD_RESP_BIT    = 3;
    localparam int WD_FLAG_BIT    = 2;
    localparam int WD_ENABLE_BIT  = 1;
    localparam int WD_UNLOCK_BIT  = 0;
    localparam int PRE_LSB        = 4;
    localparam int WD_BASE_SHIFT  = 9;
    localparam logic [3:0] PRE_MAX_VALID = 4'h7;
    localparam logic [3:0] PRE_AUTO_RST  = 4'h8;
    localparam logic [3:0] PRE_DL_RST    = 4'h9;
    // ************************************************************
    // sources, in polling order
    // ************************************************************
    localparam int NSRC = 12;
    localparam int SRC_EXT0 = 0;
    localparam int SRC_TMR0 = 1;
    localparam int SRC_EXT1 = 2;
    localparam int SRC_TMR1 = 3;
    localparam int SRC_UART = 4;
    localparam int SRC_TMR2 = 5;
    localparam int SRC_TEMP = 6;
    localparam int SRC_METR = 7;
    localparam int SRC_RTC  = 8;
    localparam int SRC_SER  = 9;
    localparam int SRC_WDOG = 10;
    localparam int SRC_SUPP = 11;
    localparam logic [3:0] NO_SRC = 4'hf;
    typedef enum logic [1:0] {
        TLIC_LVL_LOW  = 2'b00,
        TLIC_LVL_HIGH = 2'b01,
        TLIC_LVL_TOP  = 2'b10
    } tlic_level_t;
endpackage : tlic_pkg
`default_nettype wire

// file: hw/tlic_top.sv
`timescale 1ns/100ps
`default_nettype none
module tlic_top (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    input  wire logic [9:0]  irq_src,
    input  wire logic        supply_monitor,
    input  wire logic        wakeup_event,
    input  wire logic        watchdog_input_clock,
    input  wire logic        irq_ack,
    input  wire logic        irq_return,
    output logic             irq_req,
    output logic      [3:0]  irq_id,
    output logic             core_wakeup,
    output logic             wdog_reset
);
    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] ie_q, ie_d, sec_q, sec_d, lvl_q, lvl_d, wd_q, wd_d;
    logic       unlock_armed_q, unlock_armed_d;
    logic [15:0] wd_cnt_q, wd_cnt_d;
    logic [2:0] wclk_q, wclk_d;
    logic       wlvl_q, wlvl_d;
    logic [7:0] rdata_q, rdata_d;
    logic       wd_tick;
    logic       wd_expire;
    logic       wd_irq_q, wd_irq_d;
    logic       wd_rst_q, wd_rst_d;
    logic       wake_q, wake_d;
    logic [2:0] active_q, active_d;
    logic [3:0] id_q, id_d;
    logic       req_q, req_d;
    logic [tlic_pkg::NSRC-1:0] pend, en_vec, hi_vec;

    // counts once stages two and three agree; a slow edge cannot count twice
    assign wd_tick = (wclk_q[2] == wclk_q[1]) && wclk_q[1] && !wlvl_q;
    // last count before timeout; sum widened so the longest code does not wrap
    function automatic logic [15:0] tmo_last(input logic [3:0] pre);
        tmo_last = 16'((17'h1 << (5'(pre) + 5'(tlic_pkg::WD_BASE_SHIFT))) - 17'h1);
    endfunction : tmo_last
    function automatic logic [3:0] pick(input logic [tlic_pkg::NSRC-1:0] v);
        pick = tlic_pkg::NO_SRC;
        for (int i = tlic_pkg::NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                pick = 4'(i);
            end
        end
    endfunction : pick

    wire [3:0] pre = wd_q[7:tlic_pkg::PRE_LSB];
    assign wd_expire = wd_q[tlic_pkg::WD_ENABLE_BIT] && wd_tick &&
                       (pre <= tlic_pkg::PRE_MAX_VALID) &&
                       (wd_cnt_q == tmo_last(pre));

    always_comb begin
        ie_d = ie_q;
        sec_d = sec_q;
        lvl_d = lvl_q;
        wd_d = wd_q;
        unlock_armed_d = unlock_armed_q;
        wclk_d = {wclk_q[1:0], watchdog_input_clock};
        wd_cnt_d = wd_cnt_q;
        wd_irq_d = 1'b0;
        wd_rst_d = 1'b0;
        wlvl_d = (wclk_q[2] == wclk_q[1]) ? wclk_q[1] : wlvl_q;
        // count first, so that a clearing write in the same cycle wins
        if (wd_tick && wd_q[tlic_pkg::WD_ENABLE_BIT]) begin
            wd_cnt_d = 16'(wd_cnt_q + 16'h0001);
        end
        if (sfr_wr) begin
            unlock_armed_d = 1'b0;
            case (sfr_addr)
                tlic_pkg::ADDR_IRQ_ENABLE: ie_d = sfr_wdata;
                tlic_pkg::ADDR_SEC_ENABLE: sec_d = sfr_wdata;
                tlic_pkg::ADDR_LEVEL_SEL:  lvl_d = sfr_wdata;
                tlic_pkg::ADDR_WDOG_CFG: begin
                    if (unlock_armed_q) begin
                        wd_d = sfr_wdata;
                        wd_d[tlic_pkg::WD_UNLOCK_BIT] = 1'b0;
                        wd_d[tlic_pkg::WD_FLAG_BIT] = wd_q[tlic_pkg::WD_FLAG_BIT] &
                                                      sfr_wdata[tlic_pkg::WD_FLAG_BIT];
                        if (sfr_wdata[tlic_pkg::WD_ENABLE_BIT]) begin
                            wd_cnt_d = 16'h0000;
                        end
                    end else if (sfr_wdata[tlic_pkg::WD_UNLOCK_BIT]) begin
                        unlock_armed_d = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        if (wd_expire) begin
            wd_cnt_d = 16'h0000;
            wd_d[tlic_pkg::WD_FLAG_BIT] = 1'b1;
            if (wd_q[tlic_pkg::WD_RESP_BIT]) begin
                wd_irq_d = 1'b1;
            end else begin
                wd_rst_d = 1'b1;
                wd_d[tlic_pkg::WD_ENABLE_BIT] = 1'b0;
            end
        end
        if (pre == tlic_pkg::PRE_AUTO_RST || pre == tlic_pkg::PRE_DL_RST) begin
            wd_rst_d = 1'b1;
        end
        if (supply_monitor && sec_q[tlic_pkg::SUPPLY_EN_BIT]) begin
            wd_d[tlic_pkg::WD_ENABLE_BIT] = 1'b0;
        end
    end

    // ************************************************************
    // arbitration
    // ************************************************************
    always_comb begin
        pend = '0;
        pend[9:0] = irq_src;
        pend[tlic_pkg::SRC_WDOG] = wd_irq_q;
        pend[tlic_pkg::SRC_SUPP] = supply_monitor;
        en_vec = {sec_q[tlic_pkg::SUPPLY_EN_BIT], 1'b1, sec_q[tlic_pkg::SER_EN_BIT],
                  sec_q[tlic_pkg::RTC_EN_BIT], sec_q[tlic_pkg::METER_EN_BIT],
                  ie_q[6:0]} & {tlic_pkg::NSRC{ie_q[tlic_pkg::GLOBAL_EN_BIT]}};
        hi_vec = {1'b0, 1'b1, sec_q[tlic_pkg::SER_LVL_BIT],
                  sec_q[tlic_pkg::RTC_LVL_BIT], lvl_q};
    end

    logic [tlic_pkg::NSRC-1:0] cand;
    logic [3:0] top_id, hi_id, lo_id;
    assign cand = pend & en_vec;
    assign top_id = pick(cand & 12'h800);
    assign hi_id  = pick(cand & hi_vec & 12'h7ff);
    assign lo_id  = pick(cand & ~hi_vec & 12'h7ff);

    always_comb begin
        active_d = active_q;
        id_d = id_q;
        req_d = req_q;
        wake_d = wakeup_event;
        if (irq_return) begin
            if (active_q[2]) begin
                active_d[2] = 1'b0;
            end else if (active_q[1]) begin
                active_d[1] = 1'b0;
            end else begin
                active_d[0] = 1'b0;
            end
        end
        if (req_q && irq_ack) begin
            req_d = 1'b0;
            id_d = tlic_pkg::NO_SRC;
            if (id_q == 4'(tlic_pkg::SRC_SUPP)) begin
                active_d[2] = 1'b1;
            end else if (hi_vec[id_q]) begin
                active_d[1] = 1'b1;
            end else begin
                active_d[0] = 1'b1;
            end
        end else if (!req_q) begin
            if (top_id != tlic_pkg::NO_SRC && !active_q[2]) begin
                req_d = 1'b1;
                id_d = top_id;
            end else if (hi_id != tlic_pkg::NO_SRC && active_q[2:1] == 2'b00) begin
                req_d = 1'b1;
                id_d = hi_id;
            end else if (lo_id != tlic_pkg::NO_SRC && active_q == 3'b000) begin
                req_d = 1'b1;
                id_d = lo_id;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ie_q <= tlic_pkg::RST_IRQ_ENABLE;
            sec_q <= tlic_pkg::RST_SEC_ENABLE;
            lvl_q <= tlic_pkg::RST_LEVEL_SEL;
            wd_q <= tlic_pkg::RST_WDOG_CFG;
            unlock_armed_q <= 1'b0;
            wd_cnt_q <= 16'h0000;
            wclk_q <= 3'h0;
            wlvl_q <= 1'b0;
            rdata_q <= 8'h00;
            wd_irq_q <= 1'b0;
            wd_rst_q <= 1'b0;
            wake_q <= 1'b0;
            active_q <= 3'h0;
            id_q <= tlic_pkg::NO_SRC;
            req_q <= 1'b0;
        end else begin
            ie_q <= ie_d;
            sec_q <= sec_d;
            lvl_q <= lvl_d;
            wd_q <= wd_d;
            unlock_armed_q <= unlock_armed_d;
            wd_cnt_q <= wd_cnt_d;
            wclk_q <= wclk_d;
            wlvl_q <= wlvl_d;
            rdata_q <= rdata_d;
            wd_irq_q <= wd_irq_d;
            wd_rst_q <= wd_rst_d;
            wake_q <= wake_d;
            active_q <= active_d;
            id_q <= id_d;
            req_q <= req_d;
        end
    end

    // read data registered: it stands one edge after sfr_rd is taken
    always_comb begin
        case (sfr_addr)
            tlic_pkg::ADDR_IRQ_ENABLE: rdata_d = ie_q;
            tlic_pkg::ADDR_SEC_ENABLE: rdata_d = sec_q;
            tlic_pkg::ADDR_LEVEL_SEL:  rdata_d = lvl_q;
            tlic_pkg::ADDR_WDOG_CFG:   rdata_d = wd_q;
            default:                   rdata_d = 8'h00;
        endcase
        if (!sfr_rd) begin
            rdata_d = 8'h00;
        end
    end

    assign sfr_rdata = rdata_q;
    assign irq_req = req_q;
    assign irq_id = id_q;
    assign core_wakeup = wake_q;
    assign wdog_reset = wd_rst_q;

    // ************************************************************
    // checks
    // ************************************************************
    property p_lock_write;
        @(posedge clk) disable iff (srst)
        (sfr_wr && sfr_addr == tlic_pkg::ADDR_WDOG_CFG && !unlock_armed_q &&
         !sfr_wdata[tlic_pkg::WD_UNLOCK_BIT] && !wd_expire && !supply_monitor &&
         pre < tlic_pkg::PRE_AUTO_RST) |=> $stable(wd_q[7:3]);
    endproperty
    a_lock_write: assert property (p_lock_write) else $error("locked write took");
    property p_flag_sticky;
        @(posedge clk) disable iff (srst)
        (wd_q[tlic_pkg::WD_FLAG_BIT] && !(sfr_wr && sfr_addr == tlic_pkg::ADDR_WDOG_CFG))
        |=> wd_q[tlic_pkg::WD_FLAG_BIT];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");
    property p_resp;
        @(posedge clk) disable iff (srst)
        wd_expire |=> (wd_irq_q == $past(wd_q[tlic_pkg::WD_RESP_BIT])) &&
                      wd_q[tlic_pkg::WD_FLAG_BIT];
    endproperty
    a_resp: assert property (p_resp) else $error("bad watchdog response");
    property p_force_rst;
        @(posedge clk) disable iff (srst)
        (pre == tlic_pkg::PRE_AUTO_RST) |=> wdog_reset;
    endproperty
    a_force_rst: assert property (p_force_rst) else $error("no forced reset");
    property p_global;
        @(posedge clk) disable iff (srst)
        (!ie_q[tlic_pkg::GLOBAL_EN_BIT] && !req_q) |=> !req_q;
    endproperty
    a_global: assert property (p_global) else $error("request while gated");
    property p_same_level;
        @(posedge clk) disable iff (srst)
        (active_q[0] && !active_q[1] && !active_q[2] && !req_q && !irq_return)
        |=> !req_q || hi_vec[id_q] || id_q == 4'(tlic_pkg::SRC_SUPP);
    endproperty
    a_same_level: assert property (p_same_level) else $error("same level preempt");
    property p_top;
        @(posedge clk) disable iff (srst)
        (!req_q && top_id != tlic_pkg::NO_SRC && !active_q[2])
        |=> req_q && id_q == 4'(tlic_pkg::SRC_SUPP);
    endproperty
    a_top: assert property (p_top) else $error("supply not first");
    property p_high_first;
        @(posedge clk) disable iff (srst)
        (!req_q && top_id == tlic_pkg::NO_SRC && hi_id != tlic_pkg::NO_SRC &&
         active_q[2:1] == 2'b00) |=> id_q == $past(hi_id);
    endproperty
    a_high_first: assert property (p_high_first) else $error("high not first");
    sequence s_high_over_low;
        active_q == 3'b001 && !req_q && !irq_return &&
        top_id == tlic_pkg::NO_SRC && hi_id != tlic_pkg::NO_SRC;
    endsequence
    property p_high_preempt;
        @(posedge clk) disable iff (srst)
        s_high_over_low |=> req_q && id_q == $past(hi_id);
    endproperty
    a_high_preempt: assert property (p_high_preempt) else $error("no preempt of low");
    sequence s_armed_cfg_write;
        unlock_armed_q && sfr_wr && sfr_addr == tlic_pkg::ADDR_WDOG_CFG;
    endsequence
    property p_unlock_load;
        @(posedge clk) disable iff (srst)
        s_armed_cfg_write |=> wd_q[7:3] == $past(sfr_wdata[7:3]);
    endproperty
    a_unlock_load: assert property (p_unlock_load) else $error("unlocked write lost");
    property p_wake;
        @(posedge clk) disable iff (srst)
        wakeup_event |=> core_wakeup;
    endproperty
    a_wake: assert property (p_wake) else $error("wakeup not passed");
endmodule : tlic_top
`default_nettype wire

// file: test/tlic_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// core side: takes a request, ends a routine on command
// ************************************************************
module tlic_core_model (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic [3:0] ack_dly,
    input  wire logic       ret_go,
    input  wire logic       irq_req,
    input  wire logic [3:0] irq_id,
    output logic            irq_ack,
    output logic            irq_return,
    output logic      [3:0] last_id
);
    logic [3:0] cnt_q;
    // a slow ack leaves the request standing, so a late change of id would show
    always_ff @(posedge clk) begin
        cnt_q      <= (srst || !irq_req || irq_ack) ? 4'h0 : cnt_q + 4'h1;
        irq_ack    <= !srst && irq_req && !irq_ack && cnt_q == ack_dly;
        irq_return <= !srst && ret_go && !irq_return;
        if (irq_ack) begin
            last_id <= irq_id;
        end
    end
endmodule : tlic_core_model
`default_nettype wire

// file: test/test_three_level_interrupt_controller.sv
`timescale 1ns/100ps
`default_nettype none
module test_three_level_interrupt_controller;
    typedef struct packed {
        logic [7:0] ie;
        logic [7:0] sec;
        logic [7:0] lvl;
        logic [9:0] src;
        logic       supp;
        logic [3:0] id;
    } tlic_row_t;
    // ************************************************************
    // ordinary cases
    // ************************************************************
    tlic_row_t rows [9] = '{
        '{8'h82, 8'ha0, 8'h00, 10'h002, 1'b0, 4'h1},
        '{8'h02, 8'ha0, 8'h00, 10'h002, 1'b0, 4'hf},
        '{8'hff, 8'ha0, 8'h00, 10'h016, 1'b0, 4'h1},
        '{8'hff, 8'ha0, 8'h10, 10'h012, 1'b0, 4'h4},
        '{8'h81, 8'ha0, 8'h00, 10'h001, 1'b0, 4'h0},
        '{8'hc1, 8'he4, 8'h00, 10'h141, 1'b0, 4'h8},
        '{8'ha1, 8'hb1, 8'h00, 10'h221, 1'b0, 4'h9},
        '{8'h81, 8'ha8, 8'h80, 10'h081, 1'b0, 4'h7},
        '{8'hff, 8'ha2, 8'hff, 10'h3ff, 1'b1, 4'hb}
    };
    logic       clk = 1'b0;
    logic       srst, sfr_wr, sfr_rd, supply_monitor, wakeup_event, irq_ack, irq_return;
    logic       wd_clk = 1'b0;
    logic       ret_go, irq_req, core_wakeup, wdog_reset;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [9:0] irq_src;
    logic [3:0] irq_id, last_id, ack_dly;
    int         err_total = 0;
    int         tests_run = 0;
    int         n;
    always #2.5 clk = ~clk;
    // sped up from the real rate so a timeout fits the run: 8 cycles a tick
    always #20 wd_clk = ~wd_clk;
    tlic_top dut_u (.clk(clk), .srst(srst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .irq_src(irq_src), .supply_monitor(supply_monitor), .wakeup_event(wakeup_event),
        .watchdog_input_clock(wd_clk), .irq_ack(irq_ack), .irq_return(irq_return),
        .irq_req(irq_req), .irq_id(irq_id), .core_wakeup(core_wakeup),
        .wdog_reset(wdog_reset));
    tlic_core_model core_u (.clk(clk), .srst(srst), .ack_dly(ack_dly), .ret_go(ret_go),
        .irq_req(irq_req), .irq_id(irq_id), .irq_ack(irq_ack), .irq_return(irq_return),
        .last_id(last_id));
    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic give_verdict;
        if (err_total == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic ticks(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : ticks
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_wr = 1'b1;
        sfr_addr = a;
        sfr_wdata = d;
        ticks(1);
        sfr_wr = 1'b0;
        ticks(1);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
        sfr_rd = 1'b1;
        sfr_addr = a;
        ticks(1);
        chk("sfr_rdata", sfr_rdata & m, exp);
        sfr_rd = 1'b0;
        ticks(1);
    endtask : rd
    task automatic grant(input logic [3:0] exp);
        int k;
        k = 0;
        while (irq_ack !== 1'b1 && k < 40) begin
            ticks(1);
            k++;
        end
        chk("grant_wait", {7'h0, k < 40}, 8'h01);
        ticks(1);
        chk("grant_id", {4'h0, last_id}, {4'h0, exp});
    endtask : grant
    task automatic ret;
        ret_go = 1'b1;
        ticks(1);
        ret_go = 1'b0;
        ticks(2);
    endtask : ret
    task automatic wait_hi(input logic sel, output int k);
        k = 0;
        while ((sel ? wdog_reset : irq_req) !== 1'b1 && k < 6000) begin
            ticks(1);
            k++;
        end
    endtask : wait_hi
    task automatic wd_load(input logic [7:0] d);
        wr(tlic_pkg::ADDR_WDOG_CFG, 8'h01);
        wr(tlic_pkg::ADDR_WDOG_CFG, d);
    endtask : wd_load
    initial begin
        #200000;
        err_total++;
        give_verdict();
    end
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        {srst, sfr_wr, sfr_rd, supply_monitor, wakeup_event, ret_go} = 6'b100000;
        {sfr_addr, sfr_wdata, irq_src} = '0;
        ack_dly = 4'h0;
        ticks(6);
        srst = 1'b0;
        rd(tlic_pkg::ADDR_IRQ_ENABLE, 8'h00, 8'hff);
        rd(tlic_pkg::ADDR_SEC_ENABLE, 8'ha0, 8'hff);
        rd(tlic_pkg::ADDR_LEVEL_SEL, 8'h00, 8'hff);
        rd(tlic_pkg::ADDR_WDOG_CFG, 8'h10, 8'hff);
        rd(8'h55, 8'h00, 8'hff);
        foreach (rows[i]) begin
            wr(tlic_pkg::ADDR_IRQ_ENABLE, rows[i].ie);
            wr(tlic_pkg::ADDR_SEC_ENABLE, rows[i].sec);
            wr(tlic_pkg::ADDR_LEVEL_SEL, rows[i].lvl);
            irq_src = rows[i].src;
            supply_monitor = rows[i].supp;
            ticks(1);
            chk("irq_req", {7'h0, irq_req}, {7'h0, rows[i].id != tlic_pkg::NO_SRC});
            chk("irq_id", {4'h0, irq_id}, {4'h0, rows[i].id});
            if (rows[i].id != tlic_pkg::NO_SRC) begin
                grant(rows[i].id);
                {irq_src, supply_monitor} = '0;
                ret();
            end else begin
                irq_src = '0;
                ticks(1);
            end
        end
        // nesting: low, then high, then supply, unwound in order
        ack_dly = 4'h5;
        wr(tlic_pkg::ADDR_IRQ_ENABLE, 8'h8b);
        wr(tlic_pkg::ADDR_LEVEL_SEL, 8'h08);
        irq_src = 10'h002;
        grant(4'h1);
        irq_src = 10'h001;
        ticks(3);
        chk("irq_req", {7'h0, irq_req}, 8'h00);
        irq_src = 10'h009;
        grant(4'h3);
        irq_src = 10'h001;
        supply_monitor = 1'b1;
        grant(4'hb);
        supply_monitor = 1'b0;
        ret();
        ret();
        chk("irq_req", {7'h0, irq_req}, 8'h00);
        ret();
        grant(4'h0);
        irq_src = '0;
        ret();
        wakeup_event = 1'b1;
        ticks(1);
        chk("core_wakeup", {7'h0, core_wakeup}, 8'h01);
        chk("irq_req", {7'h0, irq_req}, 8'h00);
        wakeup_event = 1'b0;
        // ************************************************************
        // watchdog
        // ************************************************************
        wr(tlic_pkg::ADDR_WDOG_CFG, 8'h01);
        wr(tlic_pkg::ADDR_IRQ_ENABLE, 8'h80);
        wr(tlic_pkg::ADDR_WDOG_CFG, 8'h0a);
        rd(tlic_pkg::ADDR_WDOG_CFG, 8'h10, 8'hff);
        wd_load(8'h0a);
        rd(tlic_pkg::ADDR_WDOG_CFG, 8'h0a, 8'hff);
        wait_hi(1'b0, n);
        chk("wd_time", {7'h0, n > 4000 && n < 4200}, 8'h01);
        chk("irq_id", {4'h0, irq_id}, 8'h0a);
        grant(4'ha);
        rd(tlic_pkg::ADDR_WDOG_CFG, 8'h04, 8'h04);
        ret();
        wd_load(8'h02);
        rd(tlic_pkg::ADDR_WDOG_CFG, 8'h00, 8'h04);
        wait_hi(1'b1, n);
        chk("wd_time", {7'h0, n > 4000 && n < 4200}, 8'h01);
        rd(tlic_pkg::ADDR_WDOG_CFG, 8'h04, 8'h04);
        wd_load(8'h80);
        ticks(2);
        chk("wdog_reset", {7'h0, wdog_reset}, 8'h01);
        srst = 1'b1;
        ticks(6);
        srst = 1'b0;
        rd(tlic_pkg::ADDR_WDOG_CFG, 8'h10, 8'hff);
        chk("wdog_reset", {7'h0, wdog_reset}, 8'h00);
        wd_load(8'h90);
        ticks(2);
        chk("wdog_reset", {7'h0, wdog_reset}, 8'h01);
        give_verdict();
    end
endmodule : test_three_level_interrupt_controller
`default_nettype wire
